// file: rtl/can_err_regs.svh
// Register offsets, field positions, limits and reset values of the CAN error block
`ifndef CAN_ERR_REGS_SVH
`define CAN_ERR_REGS_SVH
// Byte offsets on the register bus
`define OFS_IRQ_FLAG    8'h00
`define OFS_IRQ_ENABLE  8'h04
`define OFS_COMM_STATUS 8'h08
`define OFS_MOD_STATUS  8'h0c
`define OFS_ERR_COUNT   8'h10
`define OFS_CONTROL     8'h14
// Flag and enable bit positions
`define FLG_RXB0   0
`define FLG_RXB1   1
`define FLG_TXB0   2
`define FLG_TXB1   3
`define FLG_TXB2   4
`define FLG_ERR    5
`define FLG_WAKE   6
`define FLG_MSGERR 7
// Communication status bit positions
`define CS_ERROR_WARNING_FLAG  0
`define CS_RX_WARNING_BIT 1
`define CS_TX_WARNING_BIT 2
`define CS_RX_PASSIVE_BIT   3
`define CS_TX_PASSIVE_BIT   4
`define CS_TX_BUS_OFF_BIT   5
`define CS_OVFL1  6
`define CS_OVFL0  7
// Fault confinement limits
`define WARN_LIMIT    9'd96
`define PASSIVE_LIMIT 9'd128
`define BUSOFF_LIMIT  9'd256
`define RX_CEILING    9'd255
`define RX_REWIND     9'd120
`define TX_ERR_STEP   9'd8
`define REC_RUN       4'd11
`define REC_SEQS      8'd128
`define STUFF_RUN     3'd6
`define CRC_POLY      15'h4599
// Reset values
`define RST_ENABLE 8'h00
`define RST_MODE   2'h0
// Interrupt codes
`define IC_NONE  3'h0
`define IC_ERR   3'h1
`define IC_TXB2  3'h2
`define IC_TXB1  3'h3
`define IC_TXB0  3'h4
`define IC_RXB1  3'h5
`define IC_RXB0  3'h6
`define IC_WAKE  3'h7
`define EIC_TX   5'h08
`define EIC_RX   5'h10
`endif

// file: rtl/can_err_pkg.sv
// Types shared by the CAN error and interrupt block
package can_err_pkg;
  // Frame field of the bit being sampled
  typedef enum logic [3:0] {
    FLD_IDLE = 4'h0, FLD_SOF = 4'h1, FLD_ARB = 4'h2, FLD_CTRL = 4'h3,
    FLD_DATA = 4'h4, FLD_CRC = 4'h5, FLD_CRCDEL = 4'h6, FLD_ACKSLOT = 4'h7,
    FLD_ACKDEL = 4'h8, FLD_EOF = 4'h9, FLD_IFS = 4'ha, FLD_ERRFRM = 4'hb
  } field_e;
  // Fault confinement state
  typedef enum logic [2:0] {
    FLT_ACTIVE = 3'b001, FLT_PASSIVE = 3'b010, FLT_BUSOFF = 3'b100
  } fault_e;
  // Operating mode of the interrupt logic
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'h0, MODE_ENH1 = 2'h1, MODE_FIFO = 2'h2
  } mode_e;
endpackage

// file: rtl/can_error_and_interrupt_logic.sv
// CAN error detection, fault confinement and interrupt flag logic
// Operation
// - Receiver checks the CRC over SOF to data end, error frame on mismatch.
// - Transmitter missing dominant ack slot flags ack error and retransmits.
// - Dominant in CRC delimiter, ack delimiter, EOF or IFS is a form error.
// - Transmitted bit differing from bus is a bit error, arbitration/ack excepted.
// - Six equal bits between SOF and CRC delimiter raise a stuff error.
// - Any error aborts the message and retransmits it as soon as possible.
// - Active state sends dominant error frames, passive state recessive ones.
// - Bus-off node neither transmits nor receives.
// - Receive and transmit error counters kept per CAN and readable.
// - Passive when either counter reaches 128, active while both below.
// - Bus-off when the transmit counter reaches 256.
// - Bus-off ends alone after 128 runs of 11 recessive bits.
// - Warning flag set while either counter is at least 96.
// - Code shows highest-priority enabled pending source, lower code wins in legacy mode.
// - Legacy 3-bit codes: none, error, TXB2, TXB1, TXB0, RXB1, RXB0, wake.
// - FIFO mode shows code 10000 for every receive interrupt.
// - Emptied transmit buffer sets its flag, shared in enhanced modes.
// - Received frame sets receive flag right after EOF, shared when enhanced.
// - Any transmit or receive error sets the message error flag.
// - Bus activity while sleeping with wake enabled sets the wake flag.
// - Overflow into occupied buffer sets overflow bit and error flag.
// - Status shows warnings, passive and bus-off; state change flags error.
`timescale 1ns/1ps
`include "can_err_regs.svh"
module can_error_and_interrupt_logic (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Bit stream from the protocol engine
  input  wire logic                 bitTick,
  input  wire logic                 busLevel,
  input  wire logic                 txBit,
  input  wire logic                 stuffBit,
  input  wire logic                 transmitting,
  input  wire can_err_pkg::field_e  field,
  input  wire logic                 frameDone,
  // Buffer events and status
  input  wire logic [2:0]           txEmpty,
  input  wire logic [1:0]           rxLoaded,
  input  wire logic [1:0]           rxOverflow,
  input  wire logic [3:0]           fifoReadPointer,
  input  wire logic                 sleeping,
  input  wire logic                 canRxPin,
  // Reactions
  output logic                      errFrameReq,
  output logic                      errFramePassive,
  output logic                      retransmit,
  output logic                      nodeOnBus,
  output logic                      canIrq
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // One CRC-15 shift step
  function automatic logic [14:0] crcStep(input logic [14:0] c, input logic b);
    logic fb;
    fb = b ^ c[14];
    crcStep = {c[13:0], 1'b0} ^ (fb ? `CRC_POLY : 15'h0000);
  endfunction

  function automatic logic [5:0] statusOf(input logic [8:0] rx, input logic [8:0] tx);
    statusOf = {tx >= `BUSOFF_LIMIT, tx >= `PASSIVE_LIMIT, rx >= `PASSIVE_LIMIT,
                tx >= `WARN_LIMIT, rx >= `WARN_LIMIT,
                (rx >= `WARN_LIMIT) || (tx >= `WARN_LIMIT)};
  endfunction

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------------
  // Error detection and fault confinement
  // ------------------------------------------------------------------
  logic [14:0]          crc, next_crc;
  logic [2:0]           run, next_run;
  logic                 lastLevel, next_lastLevel;
  logic [8:0]           rxCnt, next_rxCnt, txCnt, next_txCnt;
  logic [3:0]           recRun, next_recRun;
  logic [7:0]           recSeq, next_recSeq;
  can_err_pkg::fault_e  fault, next_fault;
  logic                 errPulse, next_errPulse, next_errFrameReq, next_errFramePassive;
  logic                 next_retransmit;
  logic                 live, inStuffSpan, crcErr, ackErr, formErr, bitErr, stuffErr, anyErr;

  // Error checks on each sampled bit
  always_comb begin
    live        = bitTick && (fault != can_err_pkg::FLT_BUSOFF);
    inStuffSpan = field inside {can_err_pkg::FLD_SOF, can_err_pkg::FLD_ARB,
                                can_err_pkg::FLD_CTRL, can_err_pkg::FLD_DATA,
                                can_err_pkg::FLD_CRC};
    crcErr   = live && !transmitting && field == can_err_pkg::FLD_CRCDEL && crc != 15'h0000;
    ackErr   = live && transmitting && field == can_err_pkg::FLD_ACKSLOT && busLevel;
    formErr  = live && !busLevel && field inside {can_err_pkg::FLD_CRCDEL,
               can_err_pkg::FLD_ACKDEL, can_err_pkg::FLD_EOF, can_err_pkg::FLD_IFS};
    bitErr   = live && transmitting && (txBit != busLevel) && inStuffSpan
               && !(txBit && field == can_err_pkg::FLD_ARB);
    stuffErr = live && inStuffSpan && busLevel == lastLevel && run == `STUFF_RUN - 3'd1
               && field != can_err_pkg::FLD_SOF;
    anyErr   = crcErr || ackErr || formErr || bitErr || stuffErr;
  end

  // Next values of detection, counters and state
  always_comb begin
    next_crc             = crc;
    next_run             = run;
    next_lastLevel       = lastLevel;
    next_rxCnt           = rxCnt;
    next_txCnt           = txCnt;
    next_recRun          = recRun;
    next_recSeq          = recSeq;
    next_errPulse        = anyErr;
    // Error frame flavour follows the state
    next_errFrameReq     = anyErr;
    next_errFramePassive = (fault == can_err_pkg::FLT_PASSIVE);
    next_retransmit      = anyErr && transmitting;
    if (bitTick) begin
      // CRC accumulates destuffed bits, seeded at SOF
      if (field == can_err_pkg::FLD_SOF)
        next_crc = crcStep(15'h0000, busLevel);
      else if (inStuffSpan && !stuffBit)
        next_crc = crcStep(crc, busLevel);
      next_lastLevel = busLevel;
      if (field == can_err_pkg::FLD_SOF || busLevel != lastLevel)
        next_run = 3'd1;
      else if (run != `STUFF_RUN)
        next_run = run + 3'd1;
    end
    // Counter updates; a transmit error weighs eight
    if (anyErr) begin
      if (transmitting)
        next_txCnt = (txCnt + `TX_ERR_STEP > `BUSOFF_LIMIT) ? `BUSOFF_LIMIT
                                                            : txCnt + `TX_ERR_STEP;
      else if (rxCnt != `RX_CEILING)
        next_rxCnt = rxCnt + 9'd1;
    end else if (frameDone && fault != can_err_pkg::FLT_BUSOFF) begin
      if (transmitting) begin
        if (txCnt != 9'd0)
          next_txCnt = txCnt - 9'd1;
      end else if (rxCnt >= `PASSIVE_LIMIT)
        next_rxCnt = `RX_REWIND;
      else if (rxCnt != 9'd0)
        next_rxCnt = rxCnt - 9'd1;
    end
    // Recovery counts runs of recessive bits
    if (fault == can_err_pkg::FLT_BUSOFF) begin
      if (bitTick) begin
        if (!busLevel)
          next_recRun = 4'd0;
        else if (recRun == `REC_RUN - 4'd1) begin
          next_recRun = 4'd0;
          next_recSeq = recSeq + 8'd1;
        end else
          next_recRun = recRun + 4'd1;
      end
      if (recSeq == `REC_SEQS) begin
        next_rxCnt  = 9'd0;
        next_txCnt  = 9'd0;
        next_recSeq = 8'd0;
      end
    end else begin
      next_recRun = 4'd0;
      next_recSeq = 8'd0;
    end
    if (next_txCnt >= `BUSOFF_LIMIT)
      next_fault = can_err_pkg::FLT_BUSOFF;
    else if (next_txCnt >= `PASSIVE_LIMIT || next_rxCnt >= `PASSIVE_LIMIT)
      next_fault = can_err_pkg::FLT_PASSIVE;
    else
      next_fault = can_err_pkg::FLT_ACTIVE;
  end

  // Detection and confinement registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      crc             <= 15'h0000;
      run             <= 3'd0;
      lastLevel       <= 1'b1;
      rxCnt           <= 9'd0;
      txCnt           <= 9'd0;
      recRun          <= 4'd0;
      recSeq          <= 8'd0;
      fault           <= can_err_pkg::FLT_ACTIVE;
      errPulse        <= 1'b0;
      errFrameReq     <= 1'b0;
      errFramePassive <= 1'b0;
      retransmit      <= 1'b0;
      nodeOnBus       <= 1'b1;
    end else begin
      crc             <= next_crc;
      run             <= next_run;
      lastLevel       <= next_lastLevel;
      rxCnt           <= next_rxCnt;
      txCnt           <= next_txCnt;
      recRun          <= next_recRun;
      recSeq          <= next_recSeq;
      fault           <= next_fault;
      errPulse        <= next_errPulse;
      errFrameReq     <= next_errFrameReq;
      errFramePassive <= next_errFramePassive;
      retransmit      <= next_retransmit;
      // Keeps the engine off the bus
      nodeOnBus       <= (next_fault != can_err_pkg::FLT_BUSOFF);
    end
  end

  AST_ACK_ERR: assert property (ackErr |=> errFrameReq && retransmit)
    else $error("ack error did not start error frame and retry");
  AST_FORM_EOF: assert property (bitTick && fault != can_err_pkg::FLT_BUSOFF
    && field == can_err_pkg::FLD_EOF && !busLevel |=> errFrameReq)
    else $error("dominant EOF bit not flagged");
  AST_PASSIVE_FRAME: assert property (errFrameReq |->
    errFramePassive == ($past(fault) == can_err_pkg::FLT_PASSIVE))
    else $error("error frame kind does not match state");
  AST_TX_STEP: assert property (ackErr && txCnt < 9'd248 |=>
    txCnt == $past(txCnt) + 9'd8)
    else $error("transmit counter did not rise by eight");
  AST_PASSIVE: assert property (txCnt < `BUSOFF_LIMIT &&
    (txCnt >= `PASSIVE_LIMIT || rxCnt >= `PASSIVE_LIMIT) |-> fault == can_err_pkg::FLT_PASSIVE)
    else $error("passive limit not honoured");
  AST_BUSOFF: assert property (fault == can_err_pkg::FLT_BUSOFF |->
    txCnt >= `BUSOFF_LIMIT && !nodeOnBus)
    else $error("bus-off state inconsistent");
  AST_RECOVER: assert property (recSeq == `REC_SEQS |=>
    fault == can_err_pkg::FLT_ACTIVE && txCnt == 9'd0)
    else $error("bus-off recovery did not complete");

  // ------------------------------------------------------------------
  // Interrupt flags and status
  // ------------------------------------------------------------------
  logic [1:0]   rxSync;
  logic [7:0]   flags, next_flags, enables, next_enables;
  logic [1:0]   ovfl, next_ovfl;
  can_err_pkg::mode_e mode, next_mode;
  logic [5:0]   status, prevStatus;
  logic         next_canIrq, wrPend, next_wrPend;
  logic [7:0]   wrAddr, next_wrAddr;
  logic [7:0]   pend, setFlags, clrFlags;
  logic [2:0]   legacyCode;
  logic [4:0]   extCode;
  logic [1:0]   setOvfl, clrOvfl;
  logic [31:0]  next_hrdata;
  logic         enh;

  // Status tracks the counters, never written
  assign status = statusOf(rxCnt, txCnt);

  // Set and clear terms of the flags
  always_comb begin
    enh      = (mode != can_err_pkg::MODE_LEGACY);
    setFlags = 8'h00;
    setOvfl  = 2'h0;
    // Per buffer or shared transmit flag
    if (enh)
      setFlags[`FLG_TXB0] = |txEmpty;
    else
      setFlags[`FLG_TXB2:`FLG_TXB0] = txEmpty;
    // Per buffer or shared receive flag
    if (enh)
      setFlags[`FLG_RXB0] = |rxLoaded;
    else
      setFlags[`FLG_RXB1:`FLG_RXB0] = rxLoaded;
    // Overflow bits, one shared when enhanced
    if (enh)
      setOvfl[0] = |rxOverflow;
    else
      setOvfl = rxOverflow;
    // Overflow or state change flags the error
    setFlags[`FLG_ERR]    = (|rxOverflow) || (status != prevStatus);
    // Wake on dominant bus while asleep
    setFlags[`FLG_WAKE]   = sleeping && enables[`FLG_WAKE] && !rxSync[1];
    setFlags[`FLG_MSGERR] = errPulse;
    clrFlags = 8'h00;
    clrOvfl  = 2'h0;
    if (wrPend && wrAddr == `OFS_IRQ_FLAG)
      clrFlags = hwdata[7:0];
    if (wrPend && wrAddr == `OFS_COMM_STATUS)
      clrOvfl = {hwdata[`CS_OVFL1], hwdata[`CS_OVFL0]};
  end

  // Interrupt code priority, lower legacy code first; enhanced order error, TX, RX, wake
  always_comb begin
    pend = flags & enables;
    if (pend[`FLG_ERR])       legacyCode = `IC_ERR;
    else if (pend[`FLG_TXB2]) legacyCode = `IC_TXB2;
    else if (pend[`FLG_TXB1]) legacyCode = `IC_TXB1;
    else if (pend[`FLG_TXB0]) legacyCode = `IC_TXB0;
    else if (pend[`FLG_RXB1]) legacyCode = `IC_RXB1;
    else if (pend[`FLG_RXB0]) legacyCode = `IC_RXB0;
    else if (pend[`FLG_WAKE]) legacyCode = `IC_WAKE;
    else                      legacyCode = `IC_NONE;
    if (pend[`FLG_ERR])       extCode = {1'b0, `IC_ERR, 1'b0};
    else if (pend[`FLG_TXB0]) extCode = `EIC_TX;
    else if (pend[`FLG_RXB0]) extCode = `EIC_RX;
    else if (pend[`FLG_WAKE]) extCode = {1'b0, `IC_WAKE, 1'b0};
    else                      extCode = 5'h00;
  end

  // Next values of flags, enables and the bus slave
  always_comb begin
    // A set in the clearing cycle wins
    next_flags   = (flags & ~clrFlags) | setFlags;
    next_ovfl    = (ovfl & ~clrOvfl) | setOvfl;
    next_enables = enables;
    next_mode    = mode;
    if (wrPend && wrAddr == `OFS_IRQ_ENABLE)
      next_enables = hwdata[7:0];
    if (wrPend && wrAddr == `OFS_CONTROL)
      next_mode = can_err_pkg::mode_e'(hwdata[1:0]);
    next_canIrq = |(next_flags & next_enables);
    // Zero-wait slave: read data fetched in the address phase
    next_wrPend = hsel && hready && htrans[1] && hwrite;
    next_wrAddr = haddr[7:0];
    next_hrdata = hrdata;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `OFS_IRQ_FLAG:    next_hrdata = {24'h0, flags};
        `OFS_IRQ_ENABLE:  next_hrdata = {24'h0, enables};
        `OFS_COMM_STATUS: next_hrdata = {24'h0, ovfl[0], ovfl[1], status};
        `OFS_MOD_STATUS:  next_hrdata = {16'h0, 4'h0, fifoReadPointer, 3'h0,
                                         enh ? extCode : {1'b0, legacyCode, 1'b0}};
        `OFS_ERR_COUNT:   next_hrdata = {7'h0, txCnt, 7'h0, rxCnt};
        `OFS_CONTROL:     next_hrdata = {30'h0, mode};
        default:          next_hrdata = 32'h0;
      endcase
    end
  end

  // Interrupt and bus registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxSync     <= 2'b11;
      flags      <= 8'h00;
      ovfl       <= 2'h0;
      enables    <= `RST_ENABLE;
      mode       <= can_err_pkg::mode_e'(`RST_MODE);
      prevStatus <= 6'h00;
      canIrq     <= 1'b0;
      wrPend     <= 1'b0;
      wrAddr     <= 8'h00;
      hrdata     <= 32'h0;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      rxSync     <= {rxSync[0], canRxPin};
      flags      <= next_flags;
      ovfl       <= next_ovfl;
      enables    <= next_enables;
      mode       <= next_mode;
      prevStatus <= status;
      canIrq     <= next_canIrq;
      wrPend     <= next_wrPend;
      wrAddr     <= next_wrAddr;
      hrdata     <= next_hrdata;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
  end

  AST_TX_FLAG: assert property (mode == can_err_pkg::MODE_LEGACY && txEmpty[0]
    |=> flags[`FLG_TXB0])
    else $error("transmit flag lost");
  AST_MSG_ERR: assert property (anyErr |=> ##1 flags[`FLG_MSGERR])
    else $error("message error flag not set");
  AST_WARN: assert property ($rose(status[`CS_ERROR_WARNING_FLAG]) |=> flags[`FLG_ERR])
    else $error("warning onset did not flag an error");
  AST_IRQ_CODE: assert property (pend[`FLG_ERR] |-> legacyCode == `IC_ERR
    && extCode == 5'h02)
    else $error("error source not at top priority");

endmodule // can_error_and_interrupt_logic

// file: bench/can_peer_node.sv
// Model of the other CAN nodes sharing the bus, as a wired-AND
`timescale 1ns/1ps
module can_peer_node (
  // Level offered by the local side and the scenario
  input  wire logic                lvl,
  input  wire can_err_pkg::field_e field,
  // Peer behaviour
  input  wire logic                ackOn,
  input  wire logic                flip,
  // Resolved bus level
  output logic                     busLevel
);
  // ----
  // Bus resolution
  // ----
  // Peers acknowledge dominant
  // Flip lets a peer override the local bit, as a real node out of step would
  assign busLevel = (lvl ^ flip) & ~(ackOn & (field == can_err_pkg::FLD_ACKSLOT));
endmodule // can_peer_node

// file: bench/can_error_and_interrupt_logic_tb.sv
// Self-checking bench for the CAN error and interrupt block
`timescale 1ns/1ps
`include "can_err_regs.svh"
`define CHK(nm, ex, gt) begin nChecks++; if ((gt) !== (ex)) begin errorCnt++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module can_error_and_interrupt_logic_tb;
  logic clock = '0, rst = '1, hsel = '0, hwrite = '0, bitTick = '0, lvl = '1, stuffBit = '0;
  logic transmitting = '0, frameDone = '0, sleeping = '0, canRxPin = '1, ackOn = '1, flip = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = '0, rxLoaded = '0, rxOverflow = '0;
  logic [2:0]  hsize = 3'h2, txEmpty = '0;
  logic [3:0]  fifoReadPointer = '0;
  logic        hreadyout, hresp, busLevel, errFrameReq, errFramePassive, retransmit, nodeOnBus;
  logic        canIrq, errHit, rtHit, passHit, lastB;
  logic [14:0] crc;
  logic [8:0]  tx;
  can_err_pkg::field_e field = can_err_pkg::FLD_IDLE;
  int errorCnt = 0, nChecks = 0, seed = 27, runLen;

  // Clock, 5 ns period
  always #2.5 clock = ~clock;

  can_error_and_interrupt_logic dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bitTick(bitTick),
    .busLevel(busLevel), .txBit(lvl), .stuffBit(stuffBit), .transmitting(transmitting),
    .field(field), .frameDone(frameDone), .txEmpty(txEmpty), .rxLoaded(rxLoaded),
    .rxOverflow(rxOverflow), .fifoReadPointer(fifoReadPointer), .sleeping(sleeping),
    .canRxPin(canRxPin), .errFrameReq(errFrameReq), .errFramePassive(errFramePassive),
    .retransmit(retransmit), .nodeOnBus(nodeOnBus), .canIrq(canIrq));
  can_peer_node peer (.lvl(lvl), .field(field), .ackOn(ackOn), .flip(flip),
    .busLevel(busLevel));

  // ----
  // Helpers
  // ----
  task automatic conclude;
    if (errorCnt == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Single AHB-Lite transfer; the watchdog bounds both waits
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'h1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'h1) @(posedge clock);
    rd = hrdata;
    hsel <= 1'h0;
  endtask
  task automatic chkReg(input string nm, input logic [7:0] a, input logic [31:0] ex);
    ahb(1'h0, a, 32'h0);
    `CHK(nm, ex, rd)
    `CHK("readyOkay", 2'h2, {hreadyout, hresp})
  endtask
  // One bit; the reaction is gathered over the two edges after sampling
  task automatic bitRaw(input can_err_pkg::field_e f, input logic b, input logic s);
    @(posedge clock);
    bitTick <= 1'h1;
    field <= f;
    lvl <= b;
    stuffBit <= s;
    @(posedge clock);
    bitTick <= 1'h0;
    repeat (2) begin
      #1;
      errHit |= errFrameReq;
      rtHit |= retransmit;
      passHit |= errFramePassive & errFrameReq;
      @(posedge clock);
    end
  endtask
  function automatic logic [14:0] crcStep(input logic [14:0] c, input logic b);
    return (c << 1) ^ ((b ^ c[14]) ? `CRC_POLY : 15'h0);
  endfunction
  // Sender inserts stuff bits so legal frames never hold six equal bits
  task automatic sendBit(input can_err_pkg::field_e f, input logic b);
    if (f != can_err_pkg::FLD_CRC) crc = crcStep(crc, b);
    bitRaw(f, b, 1'h0);
    runLen = (b == lastB) ? runLen + 1 : 1;
    lastB = b;
    if (runLen == 5) begin
      bitRaw(f, ~b, 1'h1);
      lastB = ~b;
      runLen = 1;
    end
  endtask
  task automatic rxFrame(input logic bad);
    errHit = 0;
    passHit = 0;
    runLen = 0;
    lastB = 1;
    crc = '0;
    sendBit(can_err_pkg::FLD_SOF, 1'h0);
    for (int i = 0; i < 27; i++)
      sendBit(i < 11 ? can_err_pkg::FLD_ARB : can_err_pkg::FLD_DATA, 1'($random(seed)));
    for (int i = 0; i < 15; i++)
      sendBit(can_err_pkg::FLD_CRC, crc[14 - i] ^ (bad && i == 3));
    bitRaw(can_err_pkg::FLD_CRCDEL, 1'h1, 1'h0);
    bitRaw(can_err_pkg::FLD_ACKSLOT, 1'h0, 1'h0);
    bitRaw(can_err_pkg::FLD_ACKDEL, 1'h1, 1'h0);
    repeat (7) bitRaw(can_err_pkg::FLD_EOF, 1'h1, 1'h0);
    frameDone <= !bad;
    @(posedge clock);
    frameDone <= 1'h0;
  endtask
  task automatic pulse(input logic [2:0] t, input logic [1:0] r, input logic [1:0] o);
    @(posedge clock);
    txEmpty <= t;
    rxLoaded <= r;
    rxOverflow <= o;
    @(posedge clock);
    txEmpty <= '0;
    rxLoaded <= '0;
    rxOverflow <= '0;
    repeat (2) @(posedge clock);
  endtask

  // Watchdog, well beyond the roughly 7000 cycles of the run
  initial begin
    #100000;
    errorCnt++;
    conclude;
  end

  // ----
  // Scenarios
  // ----
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    chkReg("enable", `OFS_IRQ_ENABLE, 32'h0);
    chkReg("unmapped", 8'h40, 32'h0);
    // Receive side: good, bad CRC, stuff run, dominant end of frame
    rxFrame(1'h0);
    `CHK("goodFrame", 1'h0, errHit)
    rxFrame(1'h1);
    `CHK("crcErr", 1'h1, errHit)
    `CHK("activeFrame", 1'h0, passHit)
    errHit = 0;
    bitRaw(can_err_pkg::FLD_SOF, 1'h0, 1'h0);
    repeat (4) bitRaw(can_err_pkg::FLD_ARB, 1'h0, 1'h0);
    `CHK("fiveEqual", 1'h0, errHit)
    bitRaw(can_err_pkg::FLD_ARB, 1'h0, 1'h0);
    `CHK("stuffErr", 1'h1, errHit)
    errHit = 0;
    bitRaw(can_err_pkg::FLD_EOF, 1'h0, 1'h0);
    `CHK("formErr", 1'h1, errHit)
    chkReg("counts", `OFS_ERR_COUNT, 32'h3);
    rxFrame(1'h0);
    chkReg("counts", `OFS_ERR_COUNT, 32'h2);
    chkReg("msgErr", `OFS_IRQ_FLAG, 32'h80);
    // Transmit side: arbitration exception, bit error, then ack errors
    transmitting <= 1'h1;
    errHit = 0;
    rtHit = 0;
    bitRaw(can_err_pkg::FLD_SOF, 1'h0, 1'h0);
    flip <= 1'h1;
    bitRaw(can_err_pkg::FLD_ARB, 1'h1, 1'h0);
    `CHK("arbLoss", 1'h0, errHit)
    bitRaw(can_err_pkg::FLD_DATA, 1'h0, 1'h0);
    flip <= 1'h0;
    `CHK("bitErr", 1'h1, errHit)
    `CHK("retransmit", 1'h1, rtHit)
    tx = 9'h8;
    ackOn <= 1'h0;
    for (int i = 2; i <= 32; i++) begin
      errHit = 0;
      passHit = 0;
      bitRaw(can_err_pkg::FLD_ACKSLOT, 1'h1, 1'h0);
      `CHK("ackErr", 1'h1, errHit)
      `CHK("passiveFrame", tx >= 128, passHit)
      tx = tx + 9'h8;
      chkReg("counts", `OFS_ERR_COUNT, {7'h0, tx, 16'h2});
      chkReg("status", `OFS_COMM_STATUS, {24'h0, 2'h0, tx > 255, tx >= 128, 1'h0,
        tx >= 96, 1'h0, tx >= 96});
      if (tx == 9'd96) ahb(1'h1, `OFS_IRQ_FLAG, 32'h20);
      if (tx == 9'd128) chkReg("stateFlag", `OFS_IRQ_FLAG, 32'ha0);
    end
    `CHK("busOff", 1'h0, nodeOnBus)
    errHit = 0;
    bitRaw(can_err_pkg::FLD_EOF, 1'h0, 1'h0);
    `CHK("offQuiet", 1'h0, errHit)
    // Recovery after 128 runs of 11 recessive bits
    transmitting <= 1'h0;
    repeat (128 * 11 - 1) bitRaw(can_err_pkg::FLD_IDLE, 1'h1, 1'h0);
    `CHK("stillOff", 1'h0, nodeOnBus)
    bitRaw(can_err_pkg::FLD_IDLE, 1'h1, 1'h0);
    `CHK("recovered", 1'h1, nodeOnBus)
    chkReg("counts", `OFS_ERR_COUNT, 32'h0);
    // Interrupt codes in priority order
    ahb(1'h1, `OFS_IRQ_ENABLE, 32'hff);
    ahb(1'h1, `OFS_IRQ_FLAG, 32'hff);
    pulse(3'h7, 2'h3, 2'h0);
    `CHK("irqLine", 1'h1, canIrq)
    for (int k = 0; k < 5; k++) begin
      chkReg("code", `OFS_MOD_STATUS, {28'h0, 3'(2 + k), 1'h0});
      ahb(1'h1, `OFS_IRQ_FLAG, 32'h10 >> k);
    end
    chkReg("code", `OFS_MOD_STATUS, 32'h0);
    `CHK("irqLine", 1'h0, canIrq)
    pulse(3'h0, 2'h0, 2'h2);
    chkReg("overflow", `OFS_COMM_STATUS, 32'h40);
    chkReg("code", `OFS_MOD_STATUS, 32'h2);
    ahb(1'h1, `OFS_COMM_STATUS, 32'h40);
    ahb(1'h1, `OFS_IRQ_FLAG, 32'h20);
    chkReg("overflow", `OFS_COMM_STATUS, 32'h0);
    sleeping <= 1'h1;
    canRxPin <= 1'h0;
    repeat (4) @(posedge clock);
    canRxPin <= 1'h1;
    sleeping <= 1'h0;
    repeat (3) @(posedge clock);
    chkReg("code", `OFS_MOD_STATUS, 32'he);
    ahb(1'h1, `OFS_IRQ_FLAG, 32'h40);
    chkReg("code", `OFS_MOD_STATUS, 32'h0);
    ahb(1'h1, `OFS_IRQ_ENABLE, 32'h1);
    pulse(3'h1, 2'h1, 2'h0);
    chkReg("masked", `OFS_MOD_STATUS, 32'hc);
    // Enhanced modes
    ahb(1'h1, `OFS_IRQ_FLAG, 32'hff);
    fifoReadPointer <= 4'($random(seed));
    ahb(1'h1, `OFS_CONTROL, 32'h2);
    ahb(1'h1, `OFS_IRQ_ENABLE, 32'hff);
    pulse(3'h0, 2'h2, 2'h0);
    chkReg("fifoCode", `OFS_MOD_STATUS, {20'h0, fifoReadPointer, 3'h0, 5'h10});
    chkReg("rxShared", `OFS_IRQ_FLAG, 32'h1);
    ahb(1'h1, `OFS_IRQ_FLAG, 32'hff);
    ahb(1'h1, `OFS_CONTROL, 32'h1);
    pulse(3'h4, 2'h0, 2'h0);
    chkReg("txShared", `OFS_IRQ_FLAG, 32'h4);
    chkReg("txCode", `OFS_MOD_STATUS, {20'h0, fifoReadPointer, 8'h08});
    conclude;
  end
endmodule // can_error_and_interrupt_logic_tb
